// *** verilog/capture_dma_event_threshold.sv ***
// Capture DMA event threshold block: decides when to request FIFO draining.
// Assumes FIFO write byte counts, field flag and DMA first-read strobes are on aclk.
//
// Contract
// - Request when written double words reach the field-1 threshold.
// - After a request, hold off until the DMA's first FIFO read.
// - YC modes: two pixels give two luma and one each chroma value.
// - 8-bit YC modes: one threshold unit equals eight pixels.
// - Chroma FIFOs use half the programmed threshold.
// - Raw: one unit is eight 8-bit samples or four 16-bit samples.
// - Transport: one unit is eight one-byte samples.
// - Field 2 uses its own threshold only when enabled.
// - Counting measures data entering the FIFO, after filtering.
// - Threshold register: field 1 bits 9-0, field 2 bits 25-16.
// - Reserved bits read zero and ignore writes.
// - Event count register: 12-bit counts at 11-0 and 27-16.
// - Internal counter tracks requests and selects threshold.
// - After the programmed sets, switch to the other field's threshold.
`timescale 1ns/100ps
module capture_dma_event_threshold
  import capture_dma_pkg::*;
#(
  parameter int BYTE_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bytes written into each FIFO this cycle (after any filter)
  input wire logic [2:0] luma_wr_bytes,
  input wire logic [2:0] blue_wr_bytes,
  input wire logic [2:0] red_wr_bytes,
  // Field being captured: 0 field 1, 1 field 2
  input wire logic capture_field2,
  // First DMA read of each FIFO after a request
  input wire logic luma_first_read,
  input wire logic blue_first_read,
  input wire logic red_first_read,
  // DMA request pulses
  output logic luma_dma_request,
  output logic blue_chroma_dma_request,
  output logic red_chroma_dma_request,
  // Threshold in force, for the outgoing data counter
  output logic [9:0] active_dword_threshold
);

  logic [9:0] field1_dword_threshold;
  logic [9:0] field2_dword_threshold;
  logic [11:0] field1_request_set_count;
  logic [11:0] field2_request_set_count;
  logic [2:0] mode_sel;
  logic field2_threshold_enable;
  capture_mode_t mode;
  logic yc_mode;
  logic use_field2;
  logic [11:0] sets_done;
  logic [11:0] sets_target;
  logic [BYTE_W-1:0] luma_limit;
  logic [BYTE_W-1:0] chroma_limit;
  logic luma_fire;
  logic blue_fire;
  logic red_fire;
  logic blue_seen;
  logic red_seen;
  logic luma_seen;
  logic set_done;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  // Field the set counter is on, and the field flag one cycle ago
  logic field2_status;
  logic field_prev;

  // Codes 5 to 7 match no mode: they act as a non-YC mode on field 1 only
  assign mode = capture_mode_t'(mode_sel);
  assign yc_mode = (mode == MODE_BT656_8) || (mode == MODE_YC_8);

  // Field 2 threshold only in YC modes, only when enabled, and only while the
  // set counter is on field 2; that counter follows capture_field2 between switches
  assign use_field2 = yc_mode && field2_threshold_enable && field2_status;
  assign active_dword_threshold = use_field2 ? field2_dword_threshold
                                             : field1_dword_threshold;

  // One unit is eight bytes whatever the mode: eight 8-bit pixels or samples,
  // four 16-bit raw samples; the byte count already reflects the sample width
  assign luma_limit = BYTE_W'({active_dword_threshold, 3'h0});
  // Chroma FIFOs receive half the bytes, so half the threshold
  assign chroma_limit = BYTE_W'({active_dword_threshold, 2'h0});

  // Luma (or raw/transport) FIFO counter fed by bytes entering the FIFO
  fifo_byte_counter #(.BYTE_W(BYTE_W)) u_luma (
    .aclk(aclk),
    .aresetn(aresetn),
    .limit_bytes(luma_limit),
    .wr_bytes(luma_wr_bytes),
    .first_read(luma_first_read),
    .fire(luma_fire)
  );

  // Blue chroma counter, used only in YC modes
  fifo_byte_counter #(.BYTE_W(BYTE_W)) u_blue (
    .aclk(aclk),
    .aresetn(aresetn),
    .limit_bytes(chroma_limit),
    .wr_bytes(yc_mode ? blue_wr_bytes : 3'h0),
    .first_read(blue_first_read),
    .fire(blue_fire)
  );

  // Red chroma counter, used only in YC modes
  fifo_byte_counter #(.BYTE_W(BYTE_W)) u_red (
    .aclk(aclk),
    .aresetn(aresetn),
    .limit_bytes(chroma_limit),
    .wr_bytes(yc_mode ? red_wr_bytes : 3'h0),
    .first_read(red_first_read),
    .fire(red_fire)
  );

  assign luma_dma_request = luma_fire;
  assign blue_chroma_dma_request = blue_fire;
  assign red_chroma_dma_request = red_fire;

  // A set is complete once luma, blue and red have all fired
  assign set_done = (luma_seen || luma_fire) && (blue_seen || blue_fire)
                    && (red_seen || red_fire);

  // Track which members of the current set have fired
  always_ff @(posedge aclk) begin
    if (!aresetn || !yc_mode || set_done) begin
      luma_seen <= 1'b0;
      blue_seen <= 1'b0;
      red_seen <= 1'b0;
    end else begin
      luma_seen <= luma_seen | luma_fire;
      blue_seen <= blue_seen | blue_fire;
      red_seen <= red_seen | red_fire;
    end
  end

  // Sets issued in the field the counter is on; a zero target never switches.
  // The counter restarts on the captured field whenever capture_field2
  // changes, so a miscounted field cannot leave the thresholds swapped for long
  assign sets_target = field2_status ? field2_request_set_count
                                     : field1_request_set_count;
  // Last sampled field flag, to spot the start of a new field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_prev <= 1'b0;
    end else begin
      field_prev <= capture_field2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sets_done <= '0;
      field2_status <= 1'b0;
    end else if (!yc_mode || capture_field2 != field_prev) begin
      sets_done <= '0;
      field2_status <= capture_field2;
    end else if (set_done) begin
      if (sets_target != '0 && sets_done + 12'h001 >= sets_target) begin
        sets_done <= '0;
        field2_status <= ~field2_status;
      end else begin
        sets_done <= sets_done + 12'h001;
      end
    end
  end

  // AXI write channels taken in either order, then one response
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[7:2] <= OFS_STATUS[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes honour byte strobes; reserved bits are never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field1_dword_threshold <= THRESHOLD_RESET[THR1_LSB +: THR_W];
      field2_dword_threshold <= THRESHOLD_RESET[THR2_LSB +: THR_W];
      field1_request_set_count <= EVENT_COUNT_RESET[CNT1_LSB +: CNT_W];
      field2_request_set_count <= EVENT_COUNT_RESET[CNT2_LSB +: CNT_W];
      mode_sel <= CONFIG_RESET[CFG_MODE_LSB +: 3];
      field2_threshold_enable <= CONFIG_RESET[CFG_T2EN_BIT];
    end else if (do_write) begin
      case (aw_addr[7:2])
        OFS_THRESHOLD[7:2]: begin
          if (w_strb[0]) field1_dword_threshold[7:0] <= w_data[7:0];
          if (w_strb[1]) field1_dword_threshold[9:8] <= w_data[9:8];
          if (w_strb[2]) field2_dword_threshold[7:0] <= w_data[23:16];
          if (w_strb[3]) field2_dword_threshold[9:8] <= w_data[25:24];
        end
        OFS_EVENT_COUNT[7:2]: begin
          if (w_strb[0]) field1_request_set_count[7:0] <= w_data[7:0];
          if (w_strb[1]) field1_request_set_count[11:8] <= w_data[11:8];
          if (w_strb[2]) field2_request_set_count[7:0] <= w_data[23:16];
          if (w_strb[3]) field2_request_set_count[11:8] <= w_data[27:24];
        end
        OFS_CONFIG[7:2]: begin
          if (w_strb[0]) begin
            mode_sel <= w_data[CFG_MODE_LSB +: 3];
            field2_threshold_enable <= w_data[CFG_T2EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr[7:2])
        OFS_THRESHOLD[7:2]:
          s_axi_rdata <= {6'h00, field2_dword_threshold, 6'h00, field1_dword_threshold};
        OFS_EVENT_COUNT[7:2]:
          s_axi_rdata <= {4'h0, field2_request_set_count, 4'h0, field1_request_set_count};
        OFS_CONFIG[7:2]:
          s_axi_rdata <= {27'h0, field2_threshold_enable, 1'b0, mode_sel};
        OFS_STATUS[7:2]:
          s_axi_rdata <= {3'h0, field2_status, 6'h00, active_dword_threshold,
                          sets_done};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** verilog/capture_dma_pkg.sv ***
// Package for the capture DMA event threshold block.
// Holds register offsets, field layouts, reset values and capture modes.
package capture_dma_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_THRESHOLD = 8'h00;
  localparam logic [7:0] OFS_EVENT_COUNT = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Threshold register fields
  localparam int THR1_LSB = 0;
  localparam int THR2_LSB = 16;
  localparam int THR_W = 10;

  // Event count register fields
  localparam int CNT1_LSB = 0;
  localparam int CNT2_LSB = 16;
  localparam int CNT_W = 12;

  // Config register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_T2EN_BIT = 4;

  // Reset values
  localparam logic [31:0] THRESHOLD_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENT_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // Bytes in one threshold double-word unit
  localparam int BYTES_PER_UNIT = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Capture modes, as programmed in the config register
  typedef enum logic [2:0] {
    MODE_BT656_8,
    MODE_YC_8,
    MODE_RAW_8,
    MODE_RAW_16,
    MODE_TRANSPORT
  } capture_mode_t;

endpackage

// *** verilog/fifo_byte_counter.sv ***
// Per-FIFO byte counter that raises one request per threshold crossing.
// Assumes byte counts arrive each cycle from FIFO write logic on aclk.
`timescale 1ns/100ps
module fifo_byte_counter
  import capture_dma_pkg::*;
#(
  parameter int BYTE_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Threshold in bytes and data arriving
  input wire logic [BYTE_W-1:0] limit_bytes,
  input wire logic [2:0] wr_bytes,
  // Hold-off release from the first DMA read
  input wire logic first_read,
  // Request pulse
  output logic fire
);

  logic [BYTE_W-1:0] filled;
  logic armed;
  logic [BYTE_W-1:0] sum;

  assign sum = filled + BYTE_W'(wr_bytes);

  // Count bytes entering the FIFO; a zero limit never fires. Armed drops one
  // edge after the request, so the request cycle itself must not fire again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filled <= '0;
      fire <= 1'b0;
    end else if (armed && !fire && limit_bytes != '0 && sum >= limit_bytes) begin
      filled <= sum - limit_bytes;
      fire <= 1'b1;
    end else begin
      filled <= sum;
      fire <= 1'b0;
    end
  end

  // After a request, stay quiet until the DMA first reads this FIFO
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b1;
    end else if (fire) begin
      armed <= 1'b0;
    end else if (first_read) begin
      armed <= 1'b1;
    end
  end

endmodule

// *** tb/capture_dma_checker.sv ***
// Checker for the capture DMA event threshold block.
// Sees only top-level ports; bound to every instance of the block.
`timescale 1ns/100ps
module capture_dma_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus answers
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // DMA side
  input wire logic luma_first_read,
  input wire logic blue_first_read,
  input wire logic red_first_read,
  input wire logic luma_dma_request,
  input wire logic blue_chroma_dma_request,
  input wire logic red_chroma_dma_request,
  input wire logic [9:0] active_dword_threshold
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] pend;
  // Requests still waiting for their first read; a new one here means a lost hold-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 3'h0;
    end else begin
      pend <= (pend & ~{luma_first_read, blue_first_read, red_first_read})
        | {luma_dma_request, blue_chroma_dma_request, red_chroma_dma_request};
    end
  end
  a_luma_hold_off: assert property (luma_dma_request |-> !pend[2])
    else $error("luma request while previous one unserved");
  a_blue_hold_off: assert property (blue_chroma_dma_request |-> !pend[1])
    else $error("blue request while previous one unserved");
  a_red_hold_off: assert property (red_chroma_dma_request |-> !pend[0])
    else $error("red request while previous one unserved");
  a_zero_never_fires: assert property (luma_dma_request |-> $past(active_dword_threshold) != 10'h0)
    else $error("request with zero threshold");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during answer");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !luma_dma_request && !s_axi_bvalid)
    else $error("activity after reset");
  a_luma_one_pulse: assert property (luma_dma_request |=> !luma_dma_request)
    else $error("luma request longer than one cycle");
endmodule
bind capture_dma_event_threshold capture_dma_checker i_chk (.*);

// *** tb/dma_reader_model.sv ***
// Model of the DMA controller side for one capture FIFO.
// Answers a request with a first read four cycles on, later while stalled.
`timescale 1ns/100ps
module dma_reader_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request in, stall control
  input wire logic request,
  input wire logic stall,
  // First read of the FIFO
  output logic first_read
);
  logic [2:0] wait_cnt;
  logic busy;
  // A slow controller is modelled by holding the stall high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      wait_cnt <= 3'h0;
      first_read <= 1'b0;
    end else begin
      first_read <= 1'b0;
      if (request) begin
        busy <= 1'b1;
        wait_cnt <= 3'h2;
      end else if (busy && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (busy && !stall) begin
        busy <= 1'b0;
        first_read <= 1'b1;
      end
    end
  end
endmodule

// *** tb/capture_dma_event_threshold_tb.sv ***
// Testbench for the capture DMA event threshold block.
// Drives the register bus and FIFO byte counts; three DMA models answer.
`timescale 1ns/100ps
module capture_dma_event_threshold_tb;
  import capture_dma_pkg::*;
  typedef struct {capture_mode_t mode; logic [9:0] thr; int lb; int cb;} row_t;
  logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, capture_field2 = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, rdat;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic [2:0] wb = 3'h0;
  wire logic [2:0] luma_wr_bytes = wb, blue_wr_bytes = wb, red_wr_bytes = wb;
  logic luma_first_read, blue_first_read, red_first_read;
  logic luma_dma_request, blue_chroma_dma_request, red_chroma_dma_request;
  logic [9:0] active_dword_threshold;
  int bad_count = 0, checked = 0, cycles = 0, n_luma = 0, n_blue = 0, b0, c0, lag = 0;
  // Luma needs eight bytes a unit, chroma half of that
  row_t rows [5] = '{'{MODE_BT656_8, 10'h1, 8, 4}, '{MODE_YC_8, 10'h3, 24, 12},
    '{MODE_RAW_8, 10'h2, 16, 0}, '{MODE_RAW_16, 10'h1, 8, 0}, '{MODE_TRANSPORT, 10'h5, 40, 0}};
  capture_dma_event_threshold i_dut (.*);
  dma_reader_model i_luma (.aclk(aclk), .aresetn(aresetn), .request(luma_dma_request),
    .stall(stall), .first_read(luma_first_read));
  dma_reader_model i_blue (.aclk(aclk), .aresetn(aresetn), .request(blue_chroma_dma_request),
    .stall(1'b0), .first_read(blue_first_read));
  dma_reader_model i_red (.aclk(aclk), .aresetn(aresetn), .request(red_chroma_dma_request),
    .stall(1'b0), .first_read(red_first_read));
  always #20 aclk = ~aclk;
  // Request tally and hang guard
  always @(posedge aclk) begin
    n_luma <= n_luma + int'(luma_dma_request);
    n_blue <= n_blue + int'(blue_chroma_dma_request);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Ready on the answer channel rises lag cycles in, then holds until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic [1:0] resp;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n >= lag && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n >= lag && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // One byte into every FIFO for n cycles, then time for requests to show
  task automatic feed(input int n);
    repeat (n) begin
      wb <= 3'h1;
      @(posedge aclk);
    end
    wb <= 3'h0;
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_THRESHOLD);
    chk(rdat, THRESHOLD_RESET);
    axi_rd(OFS_EVENT_COUNT);
    chk(rdat, EVENT_COUNT_RESET);
    axi_wr(OFS_THRESHOLD, 32'hffff_ffff);
    axi_rd(OFS_THRESHOLD);
    chk(rdat, 32'h03ff_03ff);
    axi_wr(OFS_EVENT_COUNT, 32'hffff_ffff);
    axi_rd(OFS_EVENT_COUNT);
    chk(rdat, 32'h0fff_0fff);
    axi_wr(OFS_EVENT_COUNT, 32'h0);
    axi_rd(8'h10);
    chk({rrsp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
    for (int i = 0; i < 5; i++) begin
      axi_wr(OFS_CONFIG, {29'h0, rows[i].mode});
      axi_wr(OFS_THRESHOLD, {22'h0, rows[i].thr});
      b0 = n_luma;
      c0 = n_blue;
      if (rows[i].cb != 0) begin
        feed(rows[i].cb - 1);
        chk(32'(n_blue - c0), 32'h0);
        feed(1);
        chk(32'(n_blue - c0), 32'h1);
        chk(32'(n_luma - b0), 32'h0);
      end
      feed(rows[i].lb - rows[i].cb - 1);
      chk(32'(n_luma - b0), 32'h0);
      feed(1);
      chk(32'(n_luma - b0), 32'h1);
    end
    // A stalled controller must see one request only, the excess fires later
    axi_wr(OFS_THRESHOLD, 32'h1);
    stall <= 1'b1;
    b0 = n_luma;
    feed(16);
    chk(32'(n_luma - b0), 32'h1);
    stall <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(32'(n_luma - b0), 32'h2);
    axi_wr(OFS_THRESHOLD, 32'h0);
    feed(16);
    chk(32'(n_luma - b0), 32'h2);
    axi_wr(OFS_THRESHOLD, 32'h0002_0001);
    capture_field2 <= 1'b1;
    axi_wr(OFS_CONFIG, 32'h11);
    chk({22'h0, active_dword_threshold}, 32'h2);
    axi_wr(OFS_CONFIG, 32'h01);
    chk({22'h0, active_dword_threshold}, 32'h1);
    axi_wr(OFS_CONFIG, 32'h12);
    chk({22'h0, active_dword_threshold}, 32'h1);
    // One set per field 1, slow answer channels; the set moves to field 2
    capture_field2 <= 1'b0;
    lag = 3;
    axi_wr(OFS_EVENT_COUNT, 32'h0002_0001);
    axi_rd(OFS_EVENT_COUNT);
    lag = 0;
    chk(rdat, 32'h0002_0001);
    axi_wr(OFS_CONFIG, 32'h11);
    chk({22'h0, active_dword_threshold}, 32'h1);
    feed(8);
    chk({22'h0, active_dword_threshold}, 32'h2);
    axi_rd(OFS_STATUS);
    chk({31'h0, rdat[28]}, 32'h1);
    // Reset in mid-run: registers and the set counter return to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_THRESHOLD);
    chk(rdat, THRESHOLD_RESET);
    axi_rd(OFS_STATUS);
    chk(rdat, 32'h0);
    conclude();
  end
endmodule
